/* rtl/agcc_top.sv */
`timescale 1ns/1ps
`default_nettype none

module agcc_top
  import agcc_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC,
  parameter int TICK_CYCLES = TICK_CYC,
  parameter logic signed [7:0] GAIN_MIN = -8'sd56,
  parameter logic signed [7:0] GAIN_MAX = 8'sd60
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic shutdown_n_pin_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire agcc_agc_req_type agc_req_i,
  input wire logic fault_r_i,
  input wire logic fault_l_i,
  input wire logic thermal_i,
  output agcc_amp_type amp_o
);

  typedef struct packed {
    agcc_phase_type phase;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic ack_ok;
    logic [7:0] ptr;
    logic ptr_tgl;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_tgl;
    logic start_seen;
  } agcc_link_type;

  typedef struct packed {
    logic oe;
    logic [7:0] tx;
  } agcc_drv_type;

  typedef struct packed {
    logic [2:0] ptr_sync;
    logic [2:0] wr_sync;
    logic [1:0] fr_sync;
    logic [1:0] fl_sync;
    logic [1:0] th_sync;
    logic [7:0] rd_ptr;
    logic [7:0] rd_data;
    logic [7:1][7:0] regs;
    agcc_pwr_type pwr;
    logic [31:0] wait_cnt;
    logic [15:0] pre_cnt;
    logic [6:0] ticks;
    logic last_dec;
    agcc_amp_type amp;
  } agcc_core_type;

  function automatic logic in_map(input logic [7:0] a);
    in_map = (a >= REG_FIRST) && (a <= REG_LAST);
  endfunction

  function automatic logic [6:0] ext_time(input logic [7:0] r);
    ext_time = {1'b0, r[TIME_W-1:0]};
  endfunction

  // reset: shutdown pin and power-on reset, released through two flops
  logic arst_n;
  logic [1:0] rst_sync_q;
  logic rst_n;

  assign arst_n = rst_n_i & shutdown_n_pin_i;
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // start condition: data falls while clock high
  logic start_tgl_q;

  always_ff @(negedge sda_i or negedge arst_n) begin
    if (!arst_n) begin
      start_tgl_q <= 1'b0;
    end else if (scl_i) begin
      start_tgl_q <= ~start_tgl_q;
    end
  end

  agcc_link_type link_q, link_d;
  agcc_drv_type drv_q, drv_d;
  agcc_core_type core_q, core_d;

  // link receive side, rising clock edge
  always_comb begin
    logic [7:0] byte_in;
    byte_in = {link_q.shift[6:0], sda_i};
    link_d = link_q;
    if (start_tgl_q != link_q.start_seen) begin
      link_d.start_seen = start_tgl_q;
      link_d.phase = PH_ADDR;
      link_d.cnt = 4'h1;
      link_d.shift = {7'h00, sda_i};
      link_d.ack_ok = 1'b0;
    end else if (link_q.phase == PH_IDLE) begin
      link_d.cnt = 4'h0;
    end else if (link_q.cnt == ACK_SLOT) begin
      link_d.cnt = 4'h0;
      case (link_q.phase)
        PH_ADDR: begin
          if (!link_q.ack_ok) begin
            link_d.phase = PH_IDLE;
          end else if (link_q.shift[0]) begin
            link_d.phase = PH_RDATA;
          end else begin
            link_d.phase = PH_REG;
          end
        end
        PH_REG: begin
          link_d.phase = PH_WDATA;
        end
        PH_RDATA: begin
          if (sda_i) begin
            link_d.phase = PH_IDLE;
          end
        end
        default: begin
          link_d.phase = link_q.phase;
        end
      endcase
    end else begin
      link_d.shift = byte_in;
      link_d.cnt = link_q.cnt + 4'h1;
      if (link_q.phase == PH_RDATA && link_q.cnt == 4'h0) begin
        link_d.ptr = link_q.ptr + 8'h01;
        link_d.ptr_tgl = ~link_q.ptr_tgl;
      end
      if (link_q.cnt == LAST_BIT) begin
        case (link_q.phase)
          PH_ADDR: begin
            link_d.ack_ok = (byte_in[7:1] == DEV_ADDR);
          end
          PH_REG: begin
            link_d.ptr = byte_in;
            link_d.ptr_tgl = ~link_q.ptr_tgl;
            link_d.ack_ok = 1'b1;
          end
          PH_WDATA: begin
            link_d.wr_addr = link_q.ptr;
            link_d.wr_data = byte_in;
            link_d.wr_tgl = ~link_q.wr_tgl;
            link_d.ptr = link_q.ptr + 8'h01;
            link_d.ptr_tgl = ~link_q.ptr_tgl;
            link_d.ack_ok = 1'b1;
          end
          default: begin
            link_d.ack_ok = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge scl_i or negedge arst_n) begin
    if (!arst_n) begin
      link_q <= '{phase: PH_IDLE, default: '0};
    end else begin
      link_q <= link_d;
    end
  end

  // link drive side, falling clock edge; read data word is latched into tx at the first bit of each byte
  always_comb begin
    logic [2:0] idx;
    idx = 3'h7 - link_q.cnt[2:0];
    drv_d = drv_q;
    drv_d.oe = 1'b0;
    if (link_q.phase != PH_IDLE && link_q.cnt == ACK_SLOT && link_q.ack_ok) begin
      drv_d.oe = 1'b1;
    end else if (link_q.phase == PH_RDATA && link_q.cnt == 4'h0) begin
      drv_d.tx = core_q.rd_data;
      drv_d.oe = ~core_q.rd_data[7];
    end else if (link_q.phase == PH_RDATA && link_q.cnt < ACK_SLOT) begin
      drv_d.oe = ~drv_q.tx[idx];
    end
  end

  always_ff @(negedge scl_i or negedge arst_n) begin
    if (!arst_n) begin
      drv_q <= '0;
    end else begin
      drv_q <= drv_d;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = drv_q.oe;

  // core: registers, power sequencing, gain timing
  always_comb begin
    logic ptr_ev;
    logic wr_ev;
    logic soft_sd;
    logic tick;
    logic hold_on;
    logic [6:0] inc_time;
    logic gate_ok;
    logic [7:0] fc;
    inc_time = 7'h00;
    fc = 8'h00;
    ptr_ev = core_q.ptr_sync[2] ^ core_q.ptr_sync[1];
    wr_ev = core_q.wr_sync[2] ^ core_q.wr_sync[1];
    core_d = core_q;
    core_d.ptr_sync = {core_q.ptr_sync[1:0], link_q.ptr_tgl};
    core_d.wr_sync = {core_q.wr_sync[1:0], link_q.wr_tgl};
    core_d.fr_sync = {core_q.fr_sync[0], fault_r_i};
    core_d.fl_sync = {core_q.fl_sync[0], fault_l_i};
    core_d.th_sync = {core_q.th_sync[0], thermal_i};
    core_d.amp.step_up = 1'b0;
    core_d.amp.step_down = 1'b0;

    if (ptr_ev) begin
      core_d.rd_ptr = link_q.ptr;
    end
    if (wr_ev && in_map(link_q.wr_addr)) begin
      if (link_q.wr_addr[2:0] == IDX_FUNC) begin
        fc = core_q.regs[IDX_FUNC];
        fc = (fc & ~FC_STORE_MASK) | (link_q.wr_data & FC_STORE_MASK);
        fc[FC_FAULT_R] = core_q.regs[IDX_FUNC][FC_FAULT_R] & link_q.wr_data[FC_FAULT_R];
        fc[FC_FAULT_L] = core_q.regs[IDX_FUNC][FC_FAULT_L] & link_q.wr_data[FC_FAULT_L];
        core_d.regs[IDX_FUNC] = fc;
      end else begin
        core_d.regs[link_q.wr_addr[2:0]] = link_q.wr_data;
      end
    end
    // fault set wins over a clearing write
    if (core_q.fr_sync[1]) begin
      core_d.regs[IDX_FUNC][FC_FAULT_R] = 1'b1;
    end
    if (core_q.fl_sync[1]) begin
      core_d.regs[IDX_FUNC][FC_FAULT_L] = 1'b1;
    end

    if (in_map(core_q.rd_ptr)) begin
      core_d.rd_data = core_q.regs[core_q.rd_ptr[2:0]];
      if (core_q.rd_ptr[2:0] == IDX_FUNC) begin
        core_d.rd_data[FC_THERMAL] = core_q.th_sync[1];
        core_d.rd_data[FC_FIXED_ONE] = 1'b1;
      end
    end else begin
      core_d.rd_data = 8'h00;
    end

    soft_sd = core_q.regs[IDX_FUNC][FC_SOFT_SD];
    case (core_q.pwr)
      PW_START: begin
        core_d.amp.gain = 8'sd0;
        core_d.ticks = 7'h00;
        core_d.pre_cnt = 16'h0000;
        core_d.last_dec = 1'b0;
        if (soft_sd) begin
          core_d.pwr = PW_SOFT;
        end else if (core_q.wait_cnt >= 32'(STARTUP_CYCLES - 1)) begin
          core_d.pwr = PW_ACTIVE;
        end else begin
          core_d.wait_cnt = core_q.wait_cnt + 32'h0000_0001;
        end
      end
      PW_ACTIVE: begin
        if (soft_sd) begin
          core_d.pwr = PW_SOFT;
        end
      end
      PW_SOFT: begin
        if (!soft_sd) begin
          core_d.pwr = PW_START;
          core_d.wait_cnt = 32'h0000_0000;
        end
      end
      default: begin
        core_d.pwr = PW_SOFT;
      end
    endcase

    // gain interval engine, only while fully active
    tick = (core_q.pre_cnt >= 16'(TICK_CYCLES - 1));
    hold_on = (core_q.regs[IDX_HOLD][TIME_W-1:0] != 6'h00);
    if (core_q.last_dec && hold_on &&
        ext_time(core_q.regs[IDX_HOLD]) > ext_time(core_q.regs[IDX_REL])) begin
      inc_time = ext_time(core_q.regs[IDX_HOLD]);
    end else begin
      inc_time = ext_time(core_q.regs[IDX_REL]);
    end
    gate_ok = !core_q.regs[IDX_FUNC][FC_NG_EN] || agc_req_i.above_gate;
    if (core_q.pwr == PW_ACTIVE) begin
      core_d.pre_cnt = tick ? 16'h0000 : core_q.pre_cnt + 16'h0001;
      if (tick && core_q.ticks != 7'h7F) begin
        core_d.ticks = core_q.ticks + 7'h01;
      end
      if (gate_ok && agc_req_i.dec && core_q.amp.gain > GAIN_MIN &&
          core_q.ticks >= ext_time(core_q.regs[IDX_ATK])) begin
        core_d.amp.gain = core_q.amp.gain - 8'sd1;
        core_d.amp.step_down = 1'b1;
        core_d.last_dec = 1'b1;
        core_d.ticks = 7'h00;
        core_d.pre_cnt = 16'h0000;
      end else if (gate_ok && agc_req_i.inc && core_q.amp.gain < GAIN_MAX &&
                   core_q.ticks >= inc_time) begin
        core_d.amp.gain = core_q.amp.gain + 8'sd1;
        core_d.amp.step_up = 1'b1;
        core_d.last_dec = 1'b0;
        core_d.ticks = 7'h00;
        core_d.pre_cnt = 16'h0000;
      end
    end

    core_d.amp.active = (core_q.pwr == PW_ACTIVE);
    core_d.amp.right_en = (core_q.pwr == PW_ACTIVE) && !core_q.th_sync[1] &&
                          core_q.regs[IDX_FUNC][FC_RIGHT_EN];
    core_d.amp.left_en = (core_q.pwr == PW_ACTIVE) && !core_q.th_sync[1] &&
                         core_q.regs[IDX_FUNC][FC_LEFT_EN];
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      core_q <= '{regs: REG_RESET, pwr: PW_START, default: '0};
    end else begin
      core_q <= core_d;
    end
  end

  assign amp_o = core_q.amp;

endmodule

`default_nettype wire

/* rtl/agcc_pkg.sv */
package agcc_pkg;

  // clock and timing
  localparam int CLK_MHZ = 200;
  localparam int CLK_PERIOD_PS = 1000000 / CLK_MHZ;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STARTUP_US = 5000;
  localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;

  // serial bus
  localparam logic [6:0] DEV_ADDR = 7'h58;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // register offsets
  localparam logic [7:0] REG_FIRST = 8'h01;
  localparam logic [7:0] REG_LAST = 8'h07;
  localparam logic [2:0] IDX_FUNC = 3'h1;
  localparam logic [2:0] IDX_ATK = 3'h2;
  localparam logic [2:0] IDX_REL = 3'h3;
  localparam logic [2:0] IDX_HOLD = 3'h4;

  // reset values, index 7 down to 1
  localparam logic [7:1][7:0] REG_RESET = {8'hC2, 8'h3A, 8'h06, 8'h00, 8'h0B, 8'h05, 8'hC3};

  // function control fields
  localparam int FC_RIGHT_EN = 7;
  localparam int FC_LEFT_EN = 6;
  localparam int FC_SOFT_SD = 5;
  localparam int FC_FAULT_R = 4;
  localparam int FC_FAULT_L = 3;
  localparam int FC_THERMAL = 2;
  localparam int FC_FIXED_ONE = 1;
  localparam int FC_NG_EN = 0;
  localparam logic [7:0] FC_STORE_MASK = 8'hE1;
  localparam int TIME_W = 6;

  typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_REG, PH_WDATA, PH_RDATA} agcc_phase_type;
  typedef enum logic [1:0] {PW_START, PW_ACTIVE, PW_SOFT} agcc_pwr_type;

  typedef struct packed {
    logic dec;
    logic inc;
    logic above_gate;
  } agcc_agc_req_type;

  typedef struct packed {
    logic right_en;
    logic left_en;
    logic active;
    logic step_up;
    logic step_down;
    logic signed [7:0] gain;
  } agcc_amp_type;

endpackage

/* sim/agcc_top_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module agcc_top_checker
  import agcc_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC,
  parameter int TICK_CYCLES = TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic shutdown_n_pin_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire agcc_amp_type amp_o
);
  wire rn = rst_n_i & shutdown_n_pin_i;
  logic [31:0] cnt_q;
  // counts cycles spent with the power state not active
  always_ff @(posedge clk_i or negedge rn) begin
    if (!rn) begin
      cnt_q <= '0;
    end else if (amp_o.active) begin
      cnt_q <= '0;
    end else if (cnt_q < 32'hFFFF) begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rn);
  property p_ack_low; scl_i && $past(scl_i) |-> $stable(sda_oe_o); endproperty
  a_ack_low: assert property (p_ack_low) else $error("sda drive moved in scl high");
  property p_od; sda_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda output not low");
  property p_scl; $changed(sda_oe_o) |-> !scl_i; endproperty
  a_scl: assert property (p_scl) else $error("sda changed while scl high");
  property p_dn; amp_o.step_down |-> amp_o.gain == $past(amp_o.gain) - 8'h01; endproperty
  a_dn: assert property (p_dn) else $error("decrease not one step");
  property p_up; amp_o.step_up |-> amp_o.gain == $past(amp_o.gain) + 8'h01; endproperty
  a_up: assert property (p_up) else $error("increase not one step");
  property p_rst;
    disable iff (1'b0) !shutdown_n_pin_i |-> amp_o == '0 && !sda_oe_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs alive in shutdown");
  property p_start; $rose(amp_o.active) |-> cnt_q >= STARTUP_CYCLES; endproperty
  a_start: assert property (p_start) else $error("active too early");
  property p_gain0; $rose(amp_o.active) |-> amp_o.gain == 8'h00; endproperty
  a_gain0: assert property (p_gain0) else $error("start gain not zero");
  property p_en;
    (amp_o.right_en || amp_o.left_en) |-> amp_o.active || $past(amp_o.active);
  endproperty
  a_en: assert property (p_en) else $error("amp enabled while inactive");
  property p_soft;
    !amp_o.active && !$past(amp_o.active) |-> !(amp_o.step_up || amp_o.step_down);
  endproperty
  a_soft: assert property (p_soft) else $error("gain step while inactive");
endmodule
bind agcc_top agcc_top_checker #(
  .STARTUP_CYCLES(STARTUP_CYCLES),
  .TICK_CYCLES(TICK_CYCLES)
) u_chk (
  .clk_i(clk_i),
  .rst_n_i(rst_n_i),
  .shutdown_n_pin_i(shutdown_n_pin_i),
  .scl_i(scl_i),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe_o(sda_oe_o),
  .amp_o(amp_o)
);
`default_nettype wire

/* sim/agcc_i2c_master.sv */
`timescale 1ns/1ps
`default_nettype none
// bus master; scl rests high between frames, sda released means pulled up
module agcc_i2c_master (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic start();
    #20 sda_o = 1'b1;
    #60 scl_o = 1'b1;
    #80 sda_o = 1'b0;
    #80 scl_o = 1'b0;
  endtask
  task automatic stop();
    #20 sda_o = 1'b0;
    #60 scl_o = 1'b1;
    #80 sda_o = 1'b1;
    #80;
  endtask
  task automatic bit_x(input logic b, output logic r);
    #20 sda_o = b;
    #60 scl_o = 1'b1;
    #40 r = sda_i;
    #40 scl_o = 1'b0;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(ack_in, ack);
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import agcc_pkg::*;
  localparam int TK = 4;
  logic clk, rst_n, sd_n, m_scl, m_sda, oe, sdo, ak;
  wire sda_w = m_sda & ~oe;
  agcc_agc_req_type req;
  agcc_amp_type amp;
  int err_count = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'h177E6;
  logic [31:0] cyc = 32'h0;
  logic [31:0] last_chg = 32'h0;
  logic [31:0] gq[$];
  logic kq[$];
  logic [55:0] q;
  logic [7:0] q8, a, r, h;
  logic gap_ok;
  agcc_top #(.STARTUP_CYCLES(20), .TICK_CYCLES(TK)) u_dut (.clk_i(clk), .rst_n_i(rst_n),
    .shutdown_n_pin_i(sd_n), .scl_i(m_scl), .sda_i(sda_w), .sda_o(sdo), .sda_oe_o(oe),
    .agc_req_i(req), .fault_r_i(1'b0), .fault_l_i(1'b0), .thermal_i(1'b0), .amp_o(amp));
  agcc_i2c_master u_mst (.scl_o(m_scl), .sda_o(m_sda), .sda_i(sda_w));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] lo_gap(logic dn, logic pdn, logic [7:0] a, logic [7:0] r,
                                         logic [7:0] h);
    if (dn) return a * TK;
    if (pdn && h != 8'h00 && h > r) return h * TK;
    return r * TK;
  endfunction
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic head(input logic [7:0] rg);
    u_mst.start();
    u_mst.xfer(8'hB0, 1'b1, q8, ak);
    check("ack_addr", ak, 1'b0);
    u_mst.xfer(rg, 1'b1, q8, ak);
    check("ack_reg", ak, 1'b0);
  endtask
  task automatic wr(input logic [7:0] rg, input int n, input logic [55:0] d);
    head(rg);
    for (int i = 0; i < n; i++) begin
      u_mst.xfer(d[8*i+:8], 1'b1, q8, ak);
      check("ack_data", ak, 1'b0);
    end
    u_mst.stop();
    repeat (10) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] rg, input int n, output logic [55:0] d);
    d = '0;
    head(rg);
    u_mst.start();
    u_mst.xfer(8'hB1, 1'b1, q8, ak);
    check("ack_rd", ak, 1'b0);
    for (int i = 0; i < n; i++) u_mst.xfer(8'hFF, i == n - 1, d[8*i+:8], ak);
    u_mst.stop();
  endtask
  task automatic set_req(input logic d, input logic i, input logic g);
    @(posedge clk);
    #1 req = '{dec: d, inc: i, above_gate: g};
  endtask
  task automatic wait_steps(input int n);
    for (int k = 0; k < 3000 && gq.size() < n; k++) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // records the spacing and direction of every gain change; cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    if (amp.step_up || amp.step_down) begin
      gq.push_back(cyc - last_chg);
      kq.push_back(amp.step_down);
      last_chg <= cyc;
    end
    if (cyc == 32'd90000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    sd_n = 1'b1;
    req = '0;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (40) @(posedge clk);
    check("startup", {amp.right_en, amp.left_en, amp.active}, 3'h7);
    set_req(1'b1, 1'b0, 1'b0);
    repeat (100) @(posedge clk);
    check("gated", gq.size(), 32'h0);
    for (int c = 0; c < 3; c++) begin
      a = 8'(rnd() % 2) + 8'h02;
      r = 8'(rnd() % 8) + 8'h06;
      h = (c == 0) ? r + 8'h03 : (c == 1) ? 8'h00 : r - 8'h01;
      wr(8'h02, 3, {h, r, a});
      rd(8'h02, 3, q);
      check("cfg", q[23:0], {h, r, a});
      gq.delete();
      kq.delete();
      set_req(1'b1, 1'b0, 1'b1);
      wait_steps(3);
      set_req(1'b0, 1'b1, 1'b1);
      wait_steps(6);
      set_req(1'b0, 1'b0, 1'b1);
      for (int i = 1; i < 6; i++) begin
        gap_ok = (gq[i] - lo_gap(kq[i], kq[i-1], a, r, h)) <= 32'h4;
        check("gap", gap_ok, 1'b1);
      end
    end
    wr(8'h01, 1, 56'h01);
    check("chan_off", {amp.right_en, amp.left_en, amp.active}, 3'h1);
    rd(8'h01, 1, q);
    check("fc", q[7:0], 8'h03);
    wr(8'h01, 1, 56'h21);
    check("soft_sd", amp.active, 1'b0);
    wr(8'h01, 1, 56'hC1);
    repeat (40) @(posedge clk);
    check("restart", {amp.right_en, amp.active, amp.gain}, {2'h3, 8'h00});
    @(posedge clk);
    #1 sd_n = 1'b0;
    repeat (3) @(posedge clk);
    check("sd_pin", {oe, amp}, 64'h0);
    #1 sd_n = 1'b1;
    repeat (40) @(posedge clk);
    rd(8'h01, 7, q);
    check("defaults", q, 56'hC23A06000B05C3);
    rd(8'h08, 1, q);
    check("unmapped", q[7:0], 8'h00);
    u_mst.start();
    u_mst.xfer(8'hB2, 1'b1, q8, ak);
    check("wrong_addr", ak, 1'b1);
    u_mst.stop();
    give_verdict();
  end
endmodule
`default_nettype wire
